// ### hdl/conv_handshake.sv
// conversion handshake: start strobe, busy, sleep and three-state result bus
`timescale 1ns/1ps
module conv_handshake
    import conv_hs_pkg::*;
#(
    parameter int CONV_CYC   = CONV_CYCLES,
    parameter int SETTLE_CYC = SETTLE_CYCLES,
    parameter int WAKE_CYC   = WAKE_CYCLES
) (
    input  wire logic                clk_sys_i,
    input  wire logic                sys_rst_i,
    input  wire logic                ce_i,
    input  wire logic                convert_start_n_i,
    input  wire logic                sleep_type_select_i,
    input  wire logic                chip_select_n_i,
    input  wire logic                read_n_i,
    input  wire logic [RESULT_W-1:0] sample_data_i,
    output logic                     busy_o,
    output logic                     track_o,
    output logic                     sleep_partial_o,
    output logic                     sleep_full_o,
    output logic                     wake_ready_o,
    output logic [RESULT_W-1:0]      result_bus_o,
    output logic [RESULT_W-1:0]      result_bus_oe_n_o,
    output conv_status_t             status_o
);
    logic                start_lvl;
    logic                start_lvl_q;
    logic                start_fall;
    logic                start_rise;
    logic                cs_lvl;
    logic                rd_lvl;
    logic                bus_en;
    conv_state_t         state_q;
    logic [CNT_W-1:0]    cnt_q;
    logic [RESULT_W-1:0] hold_q;
    logic [RESULT_W-1:0] result_q;
    logic                sleep_full_q;

    function automatic logic [CNT_W-1:0] cyc(input int n);
        cyc = CNT_W'(n - 1);
    endfunction

    pin_sync3 #(.RST_VAL(1'b1)) u_sync_start (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .pin_i     (convert_start_n_i),
        .level_o   (start_lvl)
    );
    pin_sync3 #(.RST_VAL(1'b1)) u_sync_cs (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .pin_i     (chip_select_n_i),
        .level_o   (cs_lvl)
    );
    pin_sync3 #(.RST_VAL(1'b1)) u_sync_rd (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .pin_i     (read_n_i),
        .level_o   (rd_lvl)
    );

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            start_lvl_q <= 1'b1;
        end else if (ce_i) begin
            start_lvl_q <= start_lvl;
        end
    end

    // a strobe shorter than the sync filter is missed; host keeps it long enough
    assign start_fall = start_lvl_q & ~start_lvl;
    assign start_rise = ~start_lvl_q & start_lvl;

    // main sequence
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            state_q <= ST_TRACK;
            cnt_q   <= '0;
        end else if (ce_i) begin
            case (state_q)
                ST_TRACK: begin
                    if (start_fall) begin
                        state_q <= ST_CONV;
                        cnt_q   <= cyc(CONV_CYC);
                    end
                end
                ST_CONV: begin
                    // new starts during conversion are ignored
                    if (cnt_q == '0) begin
                        state_q <= ST_SETTLE;
                        cnt_q   <= cyc(SETTLE_CYC);
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                ST_SETTLE: begin
                    if (cnt_q != '0) begin
                        cnt_q <= cnt_q - 1'b1;
                    end else if (!start_lvl) begin
                        state_q <= ST_SLEEP;
                    end else begin
                        state_q <= ST_TRACK;
                    end
                end
                ST_SLEEP: begin
                    if (start_rise) begin
                        state_q <= ST_WAKE;
                        cnt_q   <= cyc(WAKE_CYC);
                    end
                end
                ST_WAKE: begin
                    if (cnt_q == '0) begin
                        state_q <= ST_TRACK;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                default: begin
                    state_q <= ST_TRACK;
                    cnt_q   <= '0;
                end
            endcase
        end
    end

    // sample held at the start edge, result loaded when conversion ends
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            hold_q   <= RESULT_RST;
            result_q <= RESULT_RST;
        end else if (ce_i) begin
            if (state_q == ST_TRACK && start_fall) begin
                hold_q <= sample_data_i;
            end
            if (state_q == ST_CONV && cnt_q == '0) begin
                result_q <= hold_q;
            end
        end
    end

    // sleep type latched on entry so a pin change mid-sleep has no effect
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            sleep_full_q <= 1'b0;
        end else if (ce_i && state_q == ST_SETTLE && cnt_q == '0 && !start_lvl) begin
            sleep_full_q <= ~sleep_type_select_i;
        end
    end

    assign busy_o          = (state_q == ST_CONV) || (state_q == ST_SETTLE);
    assign track_o         = (state_q != ST_CONV);
    assign sleep_partial_o = (state_q == ST_SLEEP) && !sleep_full_q;
    assign sleep_full_o    = (state_q == ST_SLEEP) && sleep_full_q;
    assign wake_ready_o    = (state_q == ST_TRACK);

    assign bus_en            = !cs_lvl && !rd_lvl;
    assign result_bus_o      = result_q;
    assign result_bus_oe_n_o = {RESULT_W{~bus_en}};

    assign status_o = '{busy: busy_o, track: track_o,
                        sleep_partial: sleep_partial_o, sleep_full: sleep_full_o};

    property p_busy_start;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (ce_i && state_q == ST_TRACK && start_fall) |=> busy_o;
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy not raised");

    property p_busy_hold;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        $rose(busy_o) |-> busy_o [*2];
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");

    property p_result_loaded;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        $fell(busy_o) |-> result_q == $past(hold_q);
    endproperty
    a_result_loaded: assert property (p_result_loaded) else $error("result not loaded");

    property p_track_before_fall;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        $fell(busy_o) |-> $past(track_o);
    endproperty
    a_track_before_fall: assert property (p_track_before_fall) else $error("no track");

    sequence s_fall_low;
        $fell(busy_o) && $past(!start_lvl);
    endsequence
    property p_sleep_entry;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (ce_i and s_fall_low) |-> (sleep_partial_o || sleep_full_o);
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep missed");

    property p_bus_gate;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (result_bus_oe_n_o == '0) |-> (!cs_lvl && !rd_lvl);
    endproperty
    a_bus_gate: assert property (p_bus_gate) else $error("bus driven ungated");

    property p_bus_drive;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (!cs_lvl && !rd_lvl) |-> (result_bus_oe_n_o == '0 && result_bus_o == result_q);
    endproperty
    a_bus_drive: assert property (p_bus_drive) else $error("bus not driven");

    property p_wake;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (ce_i && state_q == ST_SLEEP && start_rise) |=> !sleep_partial_o && !sleep_full_o;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake");

    property p_sleep_type;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        $rose(sleep_full_o) |-> $past(!sleep_type_select_i);
    endproperty
    a_sleep_type: assert property (p_sleep_type) else $error("wrong sleep type");
endmodule // conv_handshake

// ### hdl/conv_hs_pkg.sv
// package: constants and types for the conversion handshake block
package conv_hs_pkg;
    localparam int          RESULT_W        = 12;
    localparam int          CLK_HZ          = 25_000_000;
    localparam int          CONV_TIME_NS    = 810;
    localparam int          CONV_CYCLES     = (CONV_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int          SETTLE_TIME_NS  = 40;
    localparam int          SETTLE_CYCLES   = (SETTLE_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int          WAKE_TIME_NS    = 1000;
    localparam int          WAKE_CYCLES     = (WAKE_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int          CNT_W           = 8;
    localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;

    typedef enum logic [2:0] {
        ST_TRACK  = 3'b000,
        ST_CONV   = 3'b001,
        ST_SETTLE = 3'b011,
        ST_SLEEP  = 3'b010,
        ST_WAKE   = 3'b110
    } conv_state_t;

    typedef struct packed {
        logic                busy;
        logic                track;
        logic                sleep_partial;
        logic                sleep_full;
    } conv_status_t;
endpackage

// ### hdl/pin_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync3 #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic clk_sys_i,
    input  wire logic sys_rst_i,
    input  wire logic ce_i,
    input  wire logic pin_i,
    output logic      level_o
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
        end else if (ce_i) begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a change counts only once stages two and three agree
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            level_o <= RST_VAL;
        end else if (ce_i && (s2_q == s3_q)) begin
            level_o <= s3_q;
        end
    end
endmodule // pin_sync3

// ### tb/host_model.sv
// host-side model: start strobe and select/read cycles toward the converter
`timescale 1ns/1ps
module host_model
    import conv_hs_pkg::*;
(
    input  wire logic                clk_sys_i,
    input  wire logic                busy_i,
    input  wire logic [RESULT_W-1:0] result_bus_i,
    input  wire logic [RESULT_W-1:0] result_bus_oe_n_i,
    output logic                     convert_start_n_o,
    output logic                     chip_select_n_o,
    output logic                     read_n_o
);
    initial begin
        convert_start_n_o = 1'b1;
        chip_select_n_o   = 1'b1;
        read_n_o          = 1'b1;
    end

    // hold off a restart or read until busy drops, waiting at most 64 cycles
    task automatic idle_wait();
        for (int i = 0; i < 64 && busy_i !== 1'b0; i++) @(posedge clk_sys_i);
    endtask

    // hold=1 keeps the strobe low through the end of conversion to request sleep
    task automatic start_conv(input logic hold);
        idle_wait();
        @(posedge clk_sys_i);
        #1 convert_start_n_o = 1'b0;
        // four cycles: far above the 15 ns floor and the 3-flop synchroniser
        repeat (4) @(posedge clk_sys_i);
        #1 convert_start_n_o = !hold;
    endtask

    task automatic release_start();
        @(posedge clk_sys_i);
        #1 convert_start_n_o = 1'b1; // rising edge wakes a sleeping device
    endtask

    task automatic read_result(output logic [RESULT_W-1:0] data, output logic ok);
        ok = 1'b0;
        data = '0;
        idle_wait();
        @(posedge clk_sys_i);
        #1 chip_select_n_o = 1'b0;
        read_n_o = 1'b0;
        for (int i = 0; i < 32 && !ok; i++) begin
            @(posedge clk_sys_i);
            if (result_bus_oe_n_i === '0) begin
                data = result_bus_i;
                ok = 1'b1;
            end
        end
        #1 chip_select_n_o = 1'b1;
        read_n_o = 1'b1;
    endtask
endmodule // host_model

// ### tb/conv_handshake_tb.sv
// self-checking bench for the conversion handshake block
`timescale 1ns/1ps
module conv_handshake_tb;
    import conv_hs_pkg::*;
    logic                clk_sys_i           = 1'b0;
    logic                sys_rst_i           = 1'b1;
    logic                sleep_type_select_i = 1'b0;
    logic [RESULT_W-1:0] sample_data_i       = 12'h000;
    logic                ce_en               = 1'b1;
    logic                start_n;
    logic                cs_n;
    logic                rd_n;
    logic                busy;
    logic                track;
    logic                slp_p;
    logic                slp_f;
    logic                wake_ready;
    logic [RESULT_W-1:0] res;
    logic [RESULT_W-1:0] res_oe_n;
    conv_status_t        status;
    int                  err_count   = 0;
    int                  check_count = 0;

    always #20 clk_sys_i = ~clk_sys_i;

    // documented counts: the start pulse must end well before conversion does,
    // or every plain start would be read as a sleep request
    conv_handshake dut_u (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ce_i(ce_en),
        .convert_start_n_i(start_n), .sleep_type_select_i(sleep_type_select_i),
        .chip_select_n_i(cs_n), .read_n_i(rd_n), .sample_data_i(sample_data_i),
        .busy_o(busy), .track_o(track), .sleep_partial_o(slp_p), .sleep_full_o(slp_f),
        .wake_ready_o(wake_ready), .result_bus_o(res), .result_bus_oe_n_o(res_oe_n),
        .status_o(status));

    host_model host_u (
        .clk_sys_i(clk_sys_i), .busy_i(busy), .result_bus_i(res),
        .result_bus_oe_n_i(res_oe_n), .convert_start_n_o(start_n),
        .chip_select_n_o(cs_n), .read_n_o(rd_n));

    task automatic summarize();
        if (err_count == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [RESULT_W-1:0] seen, exp, input string msg);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s: saw %h want %h", $time, msg, seen, exp);
        end
    endtask

    // sel 0: busy, 1: wake_ready, 2: any sleep flag
    task automatic wait_sig(input int sel, input logic v);
        logic s;
        for (int i = 0; i < 64; i++) begin
            s = (sel == 0) ? busy : (sel == 1) ? wake_ready : (slp_p | slp_f);
            if (s === v) return;
            @(posedge clk_sys_i);
            #1;
        end
        check(12'h001, 12'h000, "wait timed out");
        summarize();
    endtask

    task automatic conv_once(input logic [RESULT_W-1:0] v);
        sample_data_i = v;
        host_u.start_conv(1'b0);
        wait_sig(0, 1'b1);
        check({11'h0, track}, 12'h000, "hold during conversion");
        check({11'h0, status.busy}, 12'h001, "status busy");
        check({8'h0, status}, 12'h008, "status word");
        wait_sig(0, 1'b0);
        check(res, v, "result at busy fall");
        check({11'h0, track}, 12'h001, "tracking at busy fall");
        check({10'h0, slp_p, slp_f}, 12'h000, "no sleep with strobe high");
    endtask

    task automatic read_chk(input logic [RESULT_W-1:0] v);
        logic [RESULT_W-1:0] d;
        logic                ok;
        host_u.read_result(d, ok);
        check({11'h0, ok}, 12'h001, "bus enabled on read");
        check(d, v, "read data");
        repeat (8) @(posedge clk_sys_i);
        #1 host_u.chip_select_n_o = 1'b0;
        repeat (8) @(posedge clk_sys_i);
        check(res_oe_n, 12'hfff, "select alone keeps bus off");
        #1 host_u.chip_select_n_o = 1'b1;
        host_u.read_n_o = 1'b0;
        repeat (8) @(posedge clk_sys_i);
        check(res_oe_n, 12'hfff, "read alone keeps bus off");
        #1 host_u.read_n_o = 1'b1;
        repeat (8) @(posedge clk_sys_i);
        check(res_oe_n, 12'hfff, "bus released");
    endtask

    task automatic sleep_chk(input logic typ);
        int n;
        sleep_type_select_i = typ;
        host_u.start_conv(1'b1);
        wait_sig(0, 1'b1);
        wait_sig(0, 1'b0);
        // sleep must already hold on the edge at which busy falls
        check({10'h0, slp_p, slp_f}, {10'h0, typ, !typ}, "sleep type");
        check({11'h0, wake_ready}, 12'h000, "not ready asleep");
        host_u.release_start();
        wait_sig(2, 1'b0);
        for (n = 0; n < 64 && wake_ready !== 1'b1; n++) begin
            @(posedge clk_sys_i);
            #1;
        end
        check(12'(n), 12'(WAKE_CYCLES), "wake-up time");
        wait_sig(1, 1'b1);
    endtask

    // a low enable freezes a running conversion; busy stays up and the result still lands
    task automatic ce_chk(input logic [RESULT_W-1:0] v);
        sample_data_i = v;
        host_u.start_conv(1'b0);
        wait_sig(0, 1'b1);
        ce_en = 1'b0;
        repeat (40) @(posedge clk_sys_i);
        #1 check({10'h0, busy, track}, 12'h002, "frozen mid-conversion");
        ce_en = 1'b1;
        wait_sig(0, 1'b0);
        check(res, v, "result after freeze");
    endtask

    initial begin
        repeat (2) @(posedge clk_sys_i);
        #1 sys_rst_i = 1'b0;
        check({11'h0, busy}, 12'h000, "busy after reset");
        check(res_oe_n, 12'hfff, "bus off after reset");
        conv_once(12'hfff);
        conv_once(12'ha5c);
        read_chk(12'ha5c);
        sleep_chk(1'b1);
        sleep_chk(1'b0);
        conv_once(12'h001);
        ce_chk(12'h3c7);
        summarize();
    end
endmodule // conv_handshake_tb
